// File: logic/bcc_pkg.sv
// constants, field layouts and helpers of the bcd calendar clock
// assumes a 25 MHz system clock and a 32.768 kHz timebase pin
`default_nettype none

package bcc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int REC_US = 2;
  localparam int REC_CYCLES = (REC_US * 1000 * 1000) / CLK_NS;
  localparam int REC_W = 17;
  localparam int PRESC_W = 15;
  localparam logic [PRESC_W-1:0] PRESC_LAST = 15'h7fff;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_SEC = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_MIN = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_HOUR = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_DOW = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_DATE = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_MONTH = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_YEAR = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h01c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h020;
  localparam logic [3:0] RAM_PAGE = 4'h1;
  localparam int RAM_BYTES = 56;
  localparam logic [5:0] RAM_COUNT = 6'h38;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int HR_MODE12_BIT = 6;
  localparam int HR_PM_BIT = 5;
  localparam int CTL_WAVE_EN_BIT = 4;
  localparam logic [1:0] RATE_1HZ = 2'h0;
  localparam logic [1:0] RATE_4K = 2'h1;
  localparam logic [1:0] RATE_8K = 2'h2;
  localparam logic [1:0] RATE_32K = 2'h3;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_07 = 8'h07;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] MONTH_APR = 8'h04;
  localparam logic [7:0] MONTH_JUN = 8'h06;
  localparam logic [7:0] MONTH_SEP = 8'h09;
  localparam logic [7:0] MONTH_NOV = 8'h11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // bcd helpers
  // ****************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // year 00 counts as leap, which holds through 2099
  function automatic logic is_leap(input logic [7:0] yr);
    if (!yr[4]) begin
      is_leap = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
    end else begin
      is_leap = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    end
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
    if (mon == MONTH_FEB) begin
      last_day = is_leap(yr) ? 8'h29 : 8'h28;
    end else if (mon == MONTH_APR || mon == MONTH_JUN || mon == MONTH_SEP ||
                 mon == MONTH_NOV) begin
      last_day = 8'h30;
    end else begin
      last_day = 8'h31;
    end
  endfunction

endpackage

`default_nettype wire

// File: logic/bcc_timebase.sv
// timebase sampler, second prescaler and square wave generator
// assumes the timebase pin is asynchronous to mclk_in and far slower
`default_nettype none
`timescale 1ns/10ps

module bcc_timebase (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic timebase_input_in,
  input wire logic wave_enable_in,
  input wire logic [1:0] wave_rate_in,
  output logic sec_tick_out,
  output logic wave_oe_n_out
);
  import bcc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [PRESC_W-1:0] presc;
    logic tick;
    logic oe_n;
  } bcc_tb_state_t;

  bcc_tb_state_t s;
  bcc_tb_state_t n;
  logic level;

  // ****************************************
  // prescaler and wave select
  // ****************************************
  always_comb begin
    n = s;
    level = 1'b1;
    n.s1 = timebase_input_in;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.tick = 1'b0;
    if (s.s2 && !s.s3) begin
      n.presc = s.presc + 15'h0001;
      n.tick = (s.presc == PRESC_LAST);
    end
    case (wave_rate_in)
      RATE_1HZ: level = s.presc[14];
      RATE_4K: level = s.presc[2];
      RATE_8K: level = s.presc[1];
      RATE_32K: level = s.s2;
      default: level = 1'b1;
    endcase
    // no supply gating anywhere on this path
    n.oe_n = wave_enable_in ? level : 1'b1;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign sec_tick_out = s.tick;
  assign wave_oe_n_out = s.oe_n;

  a_tick_wrap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s.tick |-> s.presc == 15'h0000) else $error("second tick off prescaler wrap");
  a_wave_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !wave_enable_in ##1 !wave_enable_in |-> s.oe_n) else $error("wave pin driven while off");

endmodule // bcc_timebase

`default_nettype wire

// File: logic/bcc_clock_top.sv
// bcd calendar clock with general storage behind an axi4-lite slave
// assumes synchronous bus master, asynchronous timebase and supply-good pins
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
`timescale 1ns/10ps

module bcc_clock_top #(
  parameter int REC_CYC = bcc_pkg::REC_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic timebase_input_in,
  input wire logic main_supply_ok_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic wave_output_pin_out,
  output logic wave_output_pin_oe_n_out,
  input wire logic [bcc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [bcc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import bcc_pkg::*;

  localparam logic [REC_W-1:0] REC_LAST = REC_W'(REC_CYC - 1);

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] dow;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] yr;
    logic [7:0] ctl;
    logic [RAM_BYTES-1:0][7:0] ram;
    logic ok_s1;
    logic ok_s2;
    logic access_ok;
    logic [REC_W-1:0] rec_cnt;
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_en;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic sda_oe_n;
  } bcc_state_t;

  bcc_state_t s;
  bcc_state_t n;
  logic sec_tick;
  logic wave_oe_n;
  logic do_wr;
  logic [7:0] hv;
  logic day_carry;
  logic wr_ok;
  logic wr_map;
  logic [5:0] widx;
  logic [5:0] ridx;

  // ****************************************
  // timebase and square wave
  // ****************************************
  bcc_timebase u_timebase (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .timebase_input_in(timebase_input_in),
    .wave_enable_in(s.ctl[CTL_WAVE_EN_BIT]),
    .wave_rate_in(s.ctl[1:0]),
    .sec_tick_out(sec_tick),
    .wave_oe_n_out(wave_oe_n)
  );

  assign do_wr = s.have_aw && s.have_w && !s.bvalid;
  assign widx = s.aw_addr[7:2];
  assign ridx = s_axi_araddr_in[7:2];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    hv = BCD_00;
    day_carry = 1'b0;
    wr_ok = 1'b0;
    wr_map = 1'b0;

    // supply watch and recovery delay
    n.ok_s1 = main_supply_ok_in;
    n.ok_s2 = s.ok_s1;
    if (!s.ok_s2) begin
      n.access_ok = 1'b0;
      n.rec_cnt = '0;
    end else if (!s.access_ok) begin
      if (s.rec_cnt == REC_LAST) begin
        n.access_ok = 1'b1;
      end else begin
        n.rec_cnt = s.rec_cnt + 17'h0_0001;
      end
    end

    // calendar counting, never gated by supply state
    if (sec_tick) begin
      n.sec = bcd_inc(s.sec);
      if (s.sec == BCD_59) begin
        n.sec = BCD_00;
        n.min = bcd_inc(s.min);
        if (s.min == BCD_59) begin
          n.min = BCD_00;
          if (s.hr[HR_MODE12_BIT]) begin
            hv = {3'h0, s.hr[4:0]};
            if (hv == BCD_12) begin
              hv = BCD_01;
            end else begin
              hv = bcd_inc(hv);
            end
            day_carry = (s.hr[4:0] == BCD_11[4:0]) && s.hr[HR_PM_BIT];
            n.hr = {1'b0, 1'b1, s.hr[HR_PM_BIT] ^ (s.hr[4:0] == BCD_11[4:0]), hv[4:0]};
          end else begin
            if ({2'h0, s.hr[5:0]} == BCD_23) begin
              hv = BCD_00;
              day_carry = 1'b1;
            end else begin
              hv = bcd_inc({2'h0, s.hr[5:0]});
            end
            n.hr = {2'h0, hv[5:0]};
          end
        end
      end
    end
    if (day_carry) begin
      n.dow = (s.dow == BCD_07) ? BCD_01 : bcd_inc(s.dow);
      if (s.date == last_day(s.mon, s.yr)) begin
        n.date = BCD_01;
        if (s.mon == BCD_12) begin
          n.mon = BCD_01;
          n.yr = (s.yr == BCD_99) ? BCD_00 : bcd_inc(s.yr);
        end else begin
          n.mon = bcd_inc(s.mon);
        end
      end else begin
        n.date = bcd_inc(s.date);
      end
    end

    // write channels
    if (s_axi_awvalid_in && s.awready) begin
      n.aw_addr = s_axi_awaddr_in;
      n.have_aw = 1'b1;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid_in && s.wready) begin
      n.w_data = s_axi_wdata_in[7:0];
      n.w_en = s_axi_wstrb_in[0];
      n.have_w = 1'b1;
      n.wready = 1'b0;
    end
    if (do_wr) begin
      n.have_aw = 1'b0;
      n.have_w = 1'b0;
      n.bvalid = 1'b1;
      wr_map = 1'b1;
      wr_ok = s.access_ok && s.w_en;
      case (s.aw_addr)
        ADDR_SEC: if (wr_ok) n.sec = s.w_data;
        ADDR_MIN: if (wr_ok) n.min = s.w_data;
        ADDR_HOUR: if (wr_ok) n.hr = {1'b0, s.w_data[6:0]};
        ADDR_DOW: if (wr_ok) n.dow = s.w_data;
        ADDR_DATE: if (wr_ok) n.date = s.w_data;
        ADDR_MONTH: if (wr_ok) n.mon = s.w_data;
        ADDR_YEAR: if (wr_ok) n.yr = s.w_data;
        ADDR_CTRL: begin
          wr_ok = 1'b1;
          if (s.w_en) n.ctl = {3'h0, s.w_data[CTL_WAVE_EN_BIT], 2'h0, s.w_data[1:0]};
        end
        ADDR_STATUS: wr_ok = 1'b1;
        default: begin
          wr_map = (s.aw_addr[11:8] == RAM_PAGE) && (widx < RAM_COUNT);
          if (wr_map && wr_ok) begin
            n.ram[widx] = s.w_data;
          end
        end
      endcase
      if (s.aw_addr[7:2] != 6'h00 && !wr_map) begin
        wr_ok = 1'b0;
      end
      n.bresp = (wr_map && (wr_ok || !s.w_en) && (s.access_ok || s.aw_addr == ADDR_CTRL ||
                s.aw_addr == ADDR_STATUS)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end

    // read channel
    if (s_axi_arvalid_in && s.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = s.access_ok ? RESP_OKAY : RESP_SLVERR;
      n.rdata = 8'h00;
      case (s_axi_araddr_in)
        ADDR_SEC: n.rdata = s.sec;
        ADDR_MIN: n.rdata = s.min;
        ADDR_HOUR: n.rdata = s.hr;
        ADDR_DOW: n.rdata = s.dow;
        ADDR_DATE: n.rdata = s.date;
        ADDR_MONTH: n.rdata = s.mon;
        ADDR_YEAR: n.rdata = s.yr;
        ADDR_CTRL: begin
          n.rdata = s.ctl;
          n.rresp = RESP_OKAY;
        end
        ADDR_STATUS: begin
          n.rdata = {6'h00, s.ok_s2, s.access_ok};
          n.rresp = RESP_OKAY;
        end
        default: begin
          if ((s_axi_araddr_in[11:8] == RAM_PAGE) && (ridx < RAM_COUNT)) begin
            n.rdata = s.ram[ridx];
          end else begin
            n.rresp = RESP_SLVERR;
          end
        end
      endcase
      if (n.rresp != RESP_OKAY) begin
        n.rdata = 8'h00;
      end
    end
    if (s.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // serial data line is left released; sda_oe_n stays high, so the line is never driven
    n.sda_oe_n = 1'b1;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.hr <= BCD_00;
      s.dow <= BCD_01;
      s.date <= BCD_01;
      s.mon <= BCD_01;
      s.ctl <= CTL_RESET;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.sda_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign sda_out = 1'b0;
  assign sda_oe_n_out = s.sda_oe_n;
  assign wave_output_pin_out = 1'b0;
  assign wave_output_pin_oe_n_out = wave_oe_n;
  assign s_axi_awready_out = s.awready;
  assign s_axi_wready_out = s.wready;
  assign s_axi_bresp_out = s.bresp;
  assign s_axi_bvalid_out = s.bvalid;
  assign s_axi_arready_out = s.arready;
  assign s_axi_rdata_out = {24'h00_0000, s.rdata};
  assign s_axi_rresp_out = s.rresp;
  assign s_axi_rvalid_out = s.rvalid;

  // ****************************************
  // checks
  // ****************************************
  sequence s_min_roll;
    sec_tick && !do_wr && s.sec == BCD_59 && s.min == BCD_59;
  endsequence

  sequence s_day_roll;
    s_min_roll ##0 (s.hr == BCD_23 ||
      (s.hr[HR_MODE12_BIT] && s.hr[HR_PM_BIT] && s.hr[4:0] == BCD_11[4:0]));
  endsequence

  a_sec_step: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sec_tick && !do_wr && s.sec != BCD_59 |=> s.sec == bcd_inc($past(s.sec)))
    else $error("seconds did not step");
  a_min_carry: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_min_roll |=> s.sec == BCD_00 && s.min == BCD_00)
    else $error("minute carry lost");
  a_pm_toggle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_min_roll ##0 s.hr[HR_MODE12_BIT] && s.hr[4:0] == BCD_11[4:0]
    |=> s.hr[HR_PM_BIT] != $past(s.hr[HR_PM_BIT]) && s.hr[4:0] == BCD_12[4:0])
    else $error("am pm flag did not flip");
  a_month_end: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_day_roll ##0 s.mon == MONTH_APR && s.date == 8'h30
    |=> s.date == BCD_01 && s.mon == 8'h05)
    else $error("april did not end on the 30th");
  a_leap_feb: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_day_roll ##0 s.mon == MONTH_FEB && s.date == 8'h28 && is_leap(s.yr)
    |=> s.date == 8'h29 && s.mon == MONTH_FEB)
    else $error("leap february lost its 29th");
  a_dow_wrap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_day_roll ##0 s.dow == BCD_07 |=> s.dow == BCD_01)
    else $error("day of week did not wrap");
  a_access_drop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !s.ok_s2 |=> !s.access_ok && s.rec_cnt == '0)
    else $error("access kept during supply loss");
  a_access_back: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(s.access_ok) |-> $past(s.rec_cnt) == REC_LAST && $past(s.ok_s2))
    else $error("access restored at wrong time");
  a_refused_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_axi_arvalid_in && s.arready && !s.access_ok && s_axi_araddr_in == ADDR_SEC
    |=> s.rvalid && s.rresp == RESP_SLVERR && s.rdata == 8'h00)
    else $error("clock read not refused");

endmodule // bcc_clock_top

`default_nettype wire

// File: tb/bcc_osc_model.sv
// timebase source and pull-up resolution of the open-drain pins
// assumes the bench starts and stops the timebase and picks its rate
`timescale 1ns/10ps
`default_nettype none

module bcc_osc_model (
  input wire logic run_in,
  input wire logic fast_in,
  input wire logic sda_in,
  input wire logic sda_oe_n_in,
  input wire logic wave_in,
  input wire logic wave_oe_n_in,
  output logic timebase_out,
  output logic sda_line_out,
  output logic wave_line_out
);
  // ****************
  // timebase
  // ****************
  // 320 ns square wave, or an 80 ns burst mode to reach a whole second
  initial begin
    timebase_out = 1'b0;
    forever begin
      if (run_in) begin
        timebase_out = 1'b1;
        #(fast_in ? 40 : 160);
        timebase_out = 1'b0;
        #(fast_in ? 40 : 160);
      end else begin
        timebase_out = 1'b0;
        #40;
      end
    end
  end

  // ****************
  // pull-ups
  // ****************
  assign sda_line_out = sda_oe_n_in ? 1'b1 : sda_in;
  assign wave_line_out = wave_oe_n_in ? 1'b1 : wave_in;
endmodule // bcc_osc_model

`default_nettype wire

// File: tb/test_bcd_calendar_clock_with_ram.sv
// self-checking bench of the calendar clock over its register bus
// assumes the design top, its package and the timebase model
`timescale 1ns/10ps
`default_nettype none

module test_bcd_calendar_clock_with_ram;
  import bcc_pkg::*;
  logic clk = 0, rst_n = 0, ok = 0, run = 0, fast = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  wire logic tb_w, sda_l, wave_l, sda_o, sda_oe, wv_o, wv_oe, awr, wr_r, bv, arr, rv;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int errors = 0, checks_done = 0;
  logic [1:0] r;
  logic [31:0] d;

  bcc_clock_top #(.REC_CYC(8)) uut (.mclk_in(clk), .rst_n_in(rst_n), .timebase_input_in(tb_w),
    .main_supply_ok_in(ok), .sda_in(sda_l), .sda_out(sda_o), .sda_oe_n_out(sda_oe),
    .wave_output_pin_out(wv_o), .wave_output_pin_oe_n_out(wv_oe), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wr_r),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rready));
  bcc_osc_model osc (.run_in(run), .fast_in(fast), .sda_in(sda_o), .sda_oe_n_in(sda_oe),
    .wave_in(wv_o), .wave_oe_n_in(wv_oe), .timebase_out(tb_w), .sda_line_out(sda_l),
    .wave_line_out(wave_l));

  initial begin
    forever #20 clk = ~clk;
  end

  // ****************
  // shared tasks
  // ****************
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] resp);
    int n;
    logic ad, wd;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    ad = 0;
    wd = 0;
    n = 0;
    while (!(ad && wd) && n < 100) begin
      @(posedge clk);
      n++;
      if (awr && !ad) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wr_r && !wd) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do begin
      @(posedge clk);
      n++;
    end while (!bv && n < 100);
    resp = bresp;
    bready <= 0;
    if (n >= 100) errors++;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!arr && n < 100);
    arvalid <= 0;
    while (!rv && n < 100) begin
      @(posedge clk);
      n++;
    end
    v = rdata;
    resp = rresp;
    rready <= 0;
    if (n >= 100) errors++;
  endtask

  task automatic wave_count(output int n);
    logic p;
    n = 0;
    p = wave_l;
    repeat (512) begin
      @(posedge clk);
      if (wave_l && !p) n++;
      p = wave_l;
    end
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_access();
    time t0;
    rd(ADDR_SEC, d, r);
    chk({30'h0000_0000, r}, RESP_SLVERR);
    chk(d, 32'h0000_0000);
    wr(ADDR_SEC, 8'h33, r);
    chk({30'h0000_0000, r}, RESP_SLVERR);
    ok <= 1;
    t0 = $time;
    d = 0;
    while (!d[0] && $time - t0 < 4000) rd(ADDR_STATUS, d, r);
    chk({31'h0000_0000, ($time - t0) <= 40 * 30}, 32'h1);
    rd(ADDR_SEC, d, r);
    chk(d, 32'h0000_0000);
    $display("test access done");
  endtask

  task automatic t_calendar();
    logic [11:0] ad[7] = '{ADDR_SEC, ADDR_MIN, ADDR_HOUR, ADDR_DOW, ADDR_DATE, ADDR_MONTH,
      ADDR_YEAR};
    logic [7:0] set[7] = '{8'h59, 8'h59, 8'h71, 8'h07, 8'h29, 8'h02, 8'h24};
    logic [7:0] exp[7] = '{8'h00, 8'h00, 8'h52, 8'h01, 8'h01, 8'h03, 8'h24};
    int n;
    for (int i = 0; i < 7; i++) wr(ad[i], set[i], r);
    fast <= 1;
    run <= 1;
    n = 0;
    d = 32'h0000_0059;
    while (d[7:0] == 8'h59 && n < 400) begin
      repeat (500) @(posedge clk);
      rd(ADDR_SEC, d, r);
      n++;
    end
    run <= 0;
    for (int i = 0; i < 7; i++) begin
      rd(ad[i], d, r);
      chk(d, {24'h00_0000, exp[i]});
    end
    wr(ADDR_HOUR, 8'h71, r);
    rd(ADDR_HOUR, d, r);
    chk(d, 32'h0000_0071);
    $display("test calendar done");
  endtask

  task automatic t_ram();
    wr(12'h100, 8'ha5, r);
    wr(12'h1dc, 8'h5a, r);
    rd(12'h100, d, r);
    chk(d, 32'h0000_00a5);
    rd(12'h1dc, d, r);
    chk(d, 32'h0000_005a);
    rd(12'h1e0, d, r);
    chk({30'h0000_0000, r}, RESP_SLVERR);
    $display("test ram done");
  endtask

  task automatic t_wave();
    logic [1:0] rt[4] = '{RATE_32K, RATE_8K, RATE_4K, RATE_1HZ};
    int ex[4] = '{64, 16, 8, 0};
    int n;
    fast <= 0;
    run <= 1;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, {6'h04, rt[i]}, r);
      repeat (20) @(posedge clk);
      wave_count(n);
      chk({31'h0000_0000, n >= ex[i] - 1 && n <= ex[i] + 1}, 32'h1);
    end
    wr(ADDR_CTRL, 8'h03, r);
    repeat (20) @(posedge clk);
    wave_count(n);
    chk(n, 0);
    chk({31'h0000_0000, wave_l}, 32'h1);
    $display("test wave done");
  endtask

  task automatic t_power();
    int n;
    wr(ADDR_CTRL, 8'h13, r);
    ok <= 0;
    repeat (10) @(posedge clk);
    rd(12'h100, d, r);
    chk({30'h0000_0000, r}, RESP_SLVERR);
    wave_count(n);
    chk({31'h0000_0000, n >= 63 && n <= 65}, 32'h1);
    ok <= 1;
    repeat (30) @(posedge clk);
    rd(12'h100, d, r);
    chk(d, 32'h0000_00a5);
    chk({30'h0000_0000, r}, RESP_OKAY);
    chk({31'h0000_0000, sda_l}, 32'h1);
    $display("test power done");
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    t_access();
    t_calendar();
    t_ram();
    t_wave();
    t_power();
    results();
  end
endmodule // test_bcd_calendar_clock_with_ram

`default_nettype wire
